// ### design/prhg_pkg.sv
/*
  Constants shared by the entropy health gate: test windows, limits,
  state encoding and reset values.
  Assumes a single 125 MHz system clock and synchronous reset.
*/
package prhg_pkg;
  // Total-failure check: length of a run of equal raw bits that counts as total failure
  localparam int TF_RUN_LIMIT = 32;
  // Online test window in raw bits and its ones-count acceptance band
  localparam int OT_WINDOW = 256;
  localparam int OT_ONES_MIN = 96;
  localparam int OT_ONES_MAX = 160;
  // Whitener: raw bits folded into one internal bit
  localparam int FOLD_BITS = 4;
  // Reset values
  localparam logic RST_FAIL = 1'b0;
  localparam logic RST_VALID = 1'b0;
  // Gray-coded gate states along start-up, run, then blocked
  typedef enum logic [1:0] {
    PRHG_STARTUP = 2'h0,
    PRHG_RUN = 2'h1,
    PRHG_BLOCKED = 2'h3
  } prhg_state_t;
endpackage

// ### design/prhg_online_test.sv
/*
  Continuous online test: counts ones in back-to-back windows of raw
  bits and reports a pass or a defect at the end of each window.
  Assumes raw bits arrive already synchronised, one per raw_valid.
*/
`timescale 1ns/10ps
module prhg_online_test #(
  parameter int WINDOW = prhg_pkg::OT_WINDOW,
  parameter int ONES_MIN = prhg_pkg::OT_ONES_MIN,
  parameter int ONES_MAX = prhg_pkg::OT_ONES_MAX
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic raw_valid,
  input wire logic raw_bit,
  output logic window_done,
  output logic window_fail
);
  localparam int CW = $clog2(WINDOW + 1);

  typedef struct packed {
    logic [CW-1:0] bits;
    logic [CW-1:0] ones;
    logic done;
    logic fail;
  } prhg_ot_t;

  prhg_ot_t r;
  prhg_ot_t next_r;
  logic [CW-1:0] ones_now;

  // Band must fit the window, else no window could ever pass
  if (WINDOW < 2 || ONES_MIN > ONES_MAX ||
      ONES_MAX > WINDOW) begin : g_bad_param
    $error("prhg_online_test: bad window or band");
  end

  // Window restarts itself, so the test never waits on a request
  always_comb begin
    next_r = r;
    ones_now = r.ones + CW'(raw_bit);
    next_r.done = 1'b0;
    next_r.fail = 1'b0;
    if (raw_valid) begin // see (RULE_06)
      if (r.bits == CW'(WINDOW - 1)) begin
        next_r.done = 1'b1;
        next_r.fail = (ones_now < CW'(ONES_MIN)) ||
                      (ones_now > CW'(ONES_MAX)); // see (RULE_04)
        next_r.bits = '0;
        next_r.ones = '0;
      end else begin
        next_r.bits = r.bits + CW'(1);
        next_r.ones = ones_now;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign window_done = r.done;
  assign window_fail = r.fail;

  AST_FAIL_ONLY_WITH_DONE: assert property (@(posedge clk) // see (RULE_04)
    disable iff (sys_rst) window_fail |-> window_done)
    else $error("defect reported outside window end");
endmodule // prhg_online_test

// ### design/prhg_health_gate.sv
/*
  Health gate around a physical entropy source: total-failure check,
  online test, whitening and 8/16-bit word output.
  Assumes entropy_in is an asynchronous pin; the reader takes a word
  in any cycle rng_valid and clk_en are both high.
*/
`timescale 1ns/10ps
//Contract
// (RULE_01) Detect total entropy loss from the first raw bit onward.
// (RULE_02) After total failure, deliver no random words at all.
// (RULE_03) Drop any word built from raw bits after the failure.
// (RULE_04) Run the online statistical test at start-up and continuously.
// (RULE_05) Block output until start-up test passes; block again on defect.
// (RULE_06) Online test retriggers by itself, never on demand.
// (RULE_07) Output words are eight or sixteen bits wide.
// (RULE_08) Post-processing lifts per-bit entropy above 0.997.
// (RULE_09) Status flag shows failure-caused blocking until reset.
module prhg_health_gate #(
  parameter int RUN_LIMIT = prhg_pkg::TF_RUN_LIMIT,
  parameter int FOLD = prhg_pkg::FOLD_BITS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic entropy_in,
  input wire logic word16_sel,
  output logic [15:0] rng_word,
  output logic rng_valid,
  output logic gate_open,
  output logic fail_flag
);
  localparam int RW = $clog2(RUN_LIMIT + 1);
  localparam int FW = $clog2(FOLD + 1);

  typedef struct packed {
    logic [2:0] sync;
    logic stable;
    logic prev;
    logic have_prev;
    logic [RW-1:0] run;
    logic [FW-1:0] fold_cnt;
    logic fold_acc;
    logic [15:0] shift;
    logic [4:0] nbits;
    prhg_pkg::prhg_state_t state;
    logic open;
    logic [15:0] word;
    logic valid;
    logic fail;
  } prhg_st_t;

  prhg_st_t r;
  prhg_st_t next_r;
  logic raw_valid;
  logic raw_bit;
  logic ot_done;
  logic ot_fail;
  logic total_fail;
  logic [4:0] need;

  // Counters cannot serve a run limit below two or an empty fold
  if (RUN_LIMIT < 2 || FOLD < 1) begin : g_bad_param
    $error("prhg_health_gate: bad run limit or fold");
  end

  // Raw bit counts once the last two sync stages agree
  assign raw_valid = clk_en && (r.sync[2] == r.sync[1]);
  assign raw_bit = r.sync[2];
  assign need = word16_sel ? 5'h10 : 5'h08; // see (RULE_07)

  prhg_online_test #(
    .WINDOW(prhg_pkg::OT_WINDOW),
    .ONES_MIN(prhg_pkg::OT_ONES_MIN),
    .ONES_MAX(prhg_pkg::OT_ONES_MAX)
  ) u_ot (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .raw_valid(raw_valid),
    .raw_bit(raw_bit),
    .window_done(ot_done),
    .window_fail(ot_fail)
  );

  // Stuck source shows as a run of equal bits; caught on the spot
  assign total_fail = raw_valid && r.have_prev && (raw_bit == r.prev) &&
                      (r.run == RW'(RUN_LIMIT - 1)); // see (RULE_01)

  always_comb begin
    next_r = r;
    next_r.sync = {r.sync[1:0], entropy_in};
    next_r.valid = 1'b0;
    if (raw_valid) begin
      next_r.have_prev = 1'b1;
      next_r.prev = raw_bit;
      if (r.have_prev && raw_bit == r.prev) begin
        if (r.run != RW'(RUN_LIMIT)) begin
          next_r.run = r.run + RW'(1);
        end
      end else begin
        next_r.run = RW'(1);
      end
      // XOR fold: trades raw rate for entropy per output bit
      if (r.fold_cnt == FW'(FOLD - 1)) begin // see (RULE_08)
        next_r.fold_cnt = '0;
        next_r.fold_acc = 1'b0;
        next_r.shift = {r.shift[14:0], r.fold_acc ^ raw_bit};
        if (r.nbits + 5'h01 >= need) begin
          next_r.nbits = 5'h00;
          // Word leaves only from an open gate with a clean source
          if (r.state == prhg_pkg::PRHG_RUN && !total_fail && !ot_fail) begin
            next_r.valid = 1'b1; // see (RULE_05)
            next_r.word = word16_sel ?
              {r.shift[14:0], r.fold_acc ^ raw_bit} :
              {8'h00, r.shift[6:0], r.fold_acc ^ raw_bit};
          end
        end else begin
          next_r.nbits = r.nbits + 5'h01;
        end
      end else begin
        next_r.fold_cnt = r.fold_cnt + FW'(1);
        next_r.fold_acc = r.fold_acc ^ raw_bit;
      end
    end
    // Gate state machine
    case (r.state)
      prhg_pkg::PRHG_STARTUP: begin
        if (total_fail || (ot_done && ot_fail)) begin
          next_r.state = prhg_pkg::PRHG_BLOCKED;
        end else if (ot_done) begin
          next_r.state = prhg_pkg::PRHG_RUN; // see (RULE_05)
          next_r.nbits = 5'h00; // Discard bits from before the pass
        end
      end
      prhg_pkg::PRHG_RUN: begin
        if (total_fail || ot_fail) begin
          next_r.state = prhg_pkg::PRHG_BLOCKED; // see (RULE_03)
        end
      end
      default: begin
        next_r.state = prhg_pkg::PRHG_BLOCKED; // see (RULE_02)
      end
    endcase
    // Flag is sticky: only reset clears it
    if (total_fail || ot_fail) begin
      next_r.fail = 1'b1; // see (RULE_09)
    end
    // Partial word may hold post-failure bits, so it is thrown away
    if (next_r.state == prhg_pkg::PRHG_BLOCKED) begin
      next_r.nbits = 5'h00; // see (RULE_03)
      next_r.word = 16'h0000;
    end
    // Gate output registered so the pin comes straight from a flop
    next_r.open = (next_r.state == prhg_pkg::PRHG_RUN); // see (RULE_05)
  end

  // State register, frozen while clk_en is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
      r.state <= prhg_pkg::PRHG_STARTUP;
      r.fail <= prhg_pkg::RST_FAIL;
      r.valid <= prhg_pkg::RST_VALID;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign rng_word = r.word;
  assign rng_valid = r.valid;
  assign gate_open = r.open;
  assign fail_flag = r.fail;

  // Failure in an enabled cycle; a frozen cycle does not move the gate
  sequence s_failure;
    clk_en && (total_fail || ot_fail);
  endsequence

  // Start-up window closing clean in an enabled cycle
  sequence s_startup_pass;
    clk_en && r.state == prhg_pkg::PRHG_STARTUP && ot_done && !ot_fail &&
      !total_fail;
  endsequence

  // Outputs of a gate shut by a failure
  sequence s_blocked_out;
    fail_flag && !gate_open && !rng_valid;
  endsequence

  // Output gating checks
  AST_NO_WORD_AFTER_FAIL: assert property (@(posedge clk) // see (RULE_02)
    disable iff (sys_rst) fail_flag |-> !rng_valid)
    else $error("word delivered after failure");
  AST_FAIL_BLOCKS_NEXT: assert property (@(posedge clk) // see (RULE_03)
    disable iff (sys_rst) s_failure |=> s_blocked_out)
    else $error("failure did not block output");
  AST_STARTUP_BLOCKED: assert property (@(posedge clk) // see (RULE_05)
    disable iff (sys_rst) r.state == prhg_pkg::PRHG_STARTUP |-> !rng_valid)
    else $error("word during start-up test");
  AST_FLAG_STICKY: assert property (@(posedge clk) // see (RULE_09)
    disable iff (sys_rst) fail_flag |=> fail_flag)
    else $error("fail flag dropped");
  AST_BLOCKED_STAYS: assert property (@(posedge clk) // see (RULE_02)
    disable iff (sys_rst) !gate_open && fail_flag |=> !gate_open)
    else $error("gate reopened after failure");
  AST_BYTE_MODE: assert property (@(posedge clk) // see (RULE_07)
    disable iff (sys_rst) rng_valid && !$past(word16_sel) |->
    rng_word[15:8] == 8'h00)
    else $error("byte word has upper bits set");
  AST_PASS_OPENS: assert property (@(posedge clk) // see (RULE_05)
    disable iff (sys_rst) s_startup_pass |=> gate_open)
    else $error("passed start-up test did not open gate");
  AST_STUCK_DETECT: assert property (@(posedge clk) // see (RULE_01)
    disable iff (sys_rst) total_fail |=> fail_flag)
    else $error("stuck source not flagged");
  AST_WORD_ONLY_WHEN_OPEN: assert property (@(posedge clk) // see (RULE_05)
    disable iff (sys_rst) rng_valid |-> gate_open)
    else $error("word offered while gate shut");
  AST_BLOCKED_WORD_ZERO: assert property (@(posedge clk) // see (RULE_03)
    disable iff (sys_rst) fail_flag |-> rng_word == 16'h0000)
    else $error("stale word visible after failure");
  AST_RESET_CLEARS: assert property (@(posedge clk) // see (RULE_09)
    sys_rst |=> !gate_open && !rng_valid && !fail_flag)
    else $error("reset left gate or flag set");
endmodule // prhg_health_gate

// ### tb/prhg_reader.sv
/*
  Model of the on-chip processor that reads random words.
  Assumes words are taken in any cycle rng_valid and clk_en are high.
*/
`timescale 1ns/10ps
module prhg_reader (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic rng_valid,
  input wire logic [15:0] rng_word,
  output int word_cnt,
  output logic [15:0] last_word
);
  // Never stalls; a word held by a low clk_en is taken only once
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      word_cnt <= 0;
    end else if (rng_valid && clk_en) begin
      word_cnt <= word_cnt + 1;
      last_word <= rng_word;
    end
  end
endmodule // prhg_reader

// ### tb/physical_rng_health_gate_bench.sv
/*
  Self-checking bench for the entropy health gate.
  Assumes default test windows and limits from the package.
*/
`timescale 1ns/10ps
module physical_rng_health_gate_bench;
  logic clk = 1'b0;
  logic sys_rst, clk_en, entropy_in, word16_sel;
  logic [15:0] rng_word;
  logic rng_valid, gate_open, fail_flag;
  int word_cnt;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  int mark = 0;
  logic [31:0] lfsr = 32'h10D32685;
  logic [2:0] notes[$]; // Words seen, gate open, fail flag
  logic [2:0] note;
  event phase_end;

  prhg_health_gate u_prhg_health_gate (.clk(clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .entropy_in(entropy_in), .word16_sel(word16_sel),
    .rng_word(rng_word), .rng_valid(rng_valid), .gate_open(gate_open),
    .fail_flag(fail_flag));
  prhg_reader u_prhg_reader (.clk(clk), .sys_rst(sys_rst),
    .clk_en(clk_en),
    .rng_valid(rng_valid), .rng_word(rng_word), .word_cnt(word_cnt),
    .last_word());

  // 8 ns clock
  initial begin
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Kind 0 random, 1 stuck high, 2 stuck low, 3 heavily biased
  task automatic drive(input int n, input int kind, input logic sel);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      lfsr = lfsr_next(lfsr);
      word16_sel = sel;
      clk_en = (kind == 0) ? |lfsr[2:0] : 1'b1;
      // Pin held two cycles per bit so the synchroniser keeps it
      if (kind == 0 && i % 2 == 0) begin
        entropy_in = lfsr[7];
      end else if (kind != 0) begin
        entropy_in = (kind == 1) || (kind == 3 && i % 28 < 24);
      end
    end
  endtask

  task automatic check(input logic [2:0] e);
    notes.push_back(e);
    ->phase_end;
    #1;
  endtask

  task automatic do_reset();
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    mark = 0;
  endtask

  // Phase results against the oldest note
  always @(phase_end) begin
    note = notes.pop_front();
    total_checks++;
    if (((word_cnt != mark) !== note[2]) || gate_open !== note[1] ||
        fail_flag !== note[0]) begin
      error_cnt++;
      $display("Error at %0t: phase result, expected %b", $time, note);
    end
    mark = word_cnt;
  end

  // Every offered word: gate open, no failure, 8-bit words zero-extended
  always @(posedge clk) begin
    if (rng_valid === 1'b1) begin
      total_checks++;
      if (gate_open !== 1'b1 || fail_flag !== 1'b0 || (word16_sel === 1'b0
          && rng_word[15:8] !== 8'h00)) begin
        error_cnt++;
        $display("Error at %0t: word offered while blocked or too wide",
          $time);
      end
    end
    if (fail_flag === 1'b1) begin
      total_checks++;
      if (rng_word !== 16'h0000 || gate_open !== 1'b0) begin
        error_cnt++;
        $display("Error at %0t: blocked gate shows a word or opens", $time);
      end
    end
  end

  // Cut a hang short; the tests need about 6800 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      error_cnt++;
      $display("Error at %0t: timeout", $time);
      complete_run();
    end
  end

  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    entropy_in = 1'b0;
    word16_sel = 1'b0;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    check(3'h0);
    drive(200, 0, 1'b0);
    check(3'h0);
    drive(1500, 0, 1'b0);
    check(3'h6);
    drive(1500, 0, 1'b1);
    check(3'h6);
    // Long enough that one whole window holds only biased bits
    drive(600, 3, 1'b1);
    mark = word_cnt;
    drive(400, 0, 1'b1);
    check(3'h1);
    do_reset();
    drive(600, 1, 1'b0);
    check(3'h1);
    do_reset();
    drive(1500, 0, 1'b0);
    check(3'h6);
    drive(40, 2, 1'b0);
    mark = word_cnt;
    drive(400, 0, 1'b0);
    check(3'h1);
    complete_run();
  end
endmodule // physical_rng_health_gate_bench
